// File: l2pf_busq.sv
// model: system bus request queue that stalls and reports heavy load
`timescale 1ns/1ps
module l2pf_busq
(
   // clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // bench controls
   input  wire logic stall,
   input  wire logic hold,
   input  wire logic busy_req,
   // request queue side
   input  wire logic req_valid,
   output logic      req_ready_ff,
   output logic      bus_busy_ff
);
   // =========================================
   // acceptance: one slot, busy for a cycle after each take
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         req_ready_ff <= 1'b0;
      else
         req_ready_ff <= !(stall || hold || (req_valid && req_ready_ff));
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         bus_busy_ff <= 1'b0;
      else
         bus_busy_ff <= busy_req;
   end
endmodule

// File: l2pf_pkg.sv
// package: prefetcher constants, types and shared helpers
package l2pf_pkg;
   localparam int ADDR_W     = 32;
   localparam int LINE_BYTES = 64;
   localparam int LINE_OFF   = $clog2(LINE_BYTES);
   localparam int LINE_W     = ADDR_W - LINE_OFF;
   // other models of the family use 256
   localparam int TRIG_BYTES = 512;
   localparam int ASC_N      = 16;
   localparam int DSC_N      = 4;

   typedef logic [LINE_W-1:0] l2pf_line_t;

   localparam l2pf_line_t TRIG_LINES = l2pf_line_t'(TRIG_BYTES / LINE_BYTES);
   localparam l2pf_line_t LINE_STEP  = l2pf_line_t'(1);
   localparam l2pf_line_t PAIR_BIT   = l2pf_line_t'(1);

   typedef enum logic [1:0] {L2PF_LOAD, L2PF_STORE, L2PF_SWPF} l2pf_acc_t;
   typedef enum logic [1:0] {L2PF_RD, L2PF_RFO, L2PF_PF} l2pf_req_t;

   // true when line 'to' lies past 'from' in the given direction,
   // no further away than the trigger distance
   function automatic logic l2pf_near(l2pf_line_t from, l2pf_line_t to,
                                      logic up);
      if (up)
      begin
         return (to > from) && ((to - from) <= TRIG_LINES);
      end
      return (from > to) && ((from - to) <= TRIG_LINES);
   endfunction

   function automatic logic [ADDR_W-1:0] l2pf_addr(l2pf_line_t l);
      return {l, {LINE_OFF{1'b0}}};
   endfunction
endpackage

// File: l2pf_tb.sv
// testbench: prefetcher stream, pairing, priority and look-ahead checks
`timescale 1ns/1ps
module tb;
   import l2pf_pkg::*;
   // =========================================
   // signals
   logic              clock, reset_n, clk_en, acc_valid, acc_l2_hit;
   l2pf_acc_t         acc_kind;
   logic [ADDR_W-1:0] acc_addr, req_addr_ff, l1pf_addr_ff;
   l2pf_req_t         req_kind_ff;
   logic              acc_ready_ff, req_valid_ff, req_ready, bus_busy;
   logic              pf_cancel_ff, l1pf_valid_ff, acc_taken;
   logic              stall, hold, busy_req;
   logic [ADDR_W+1:0] exp_q[$];
   logic [ADDR_W-1:0] l1_q[$];
   int                err_count, samples_checked, cancel_seen, cycles, n0;
   integer            seed;
   l2pf_line_t        base;

   l2pf_top dut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
      .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_addr(acc_addr),
      .acc_l2_hit(acc_l2_hit), .acc_ready_ff(acc_ready_ff),
      .req_valid_ff(req_valid_ff), .req_kind_ff(req_kind_ff),
      .req_addr_ff(req_addr_ff), .req_ready(req_ready),
      .bus_busy(bus_busy), .pf_cancel_ff(pf_cancel_ff),
      .l1pf_valid_ff(l1pf_valid_ff), .l1pf_addr_ff(l1pf_addr_ff));

   l2pf_busq u_busq (.clock(clock), .reset_n(reset_n), .stall(stall),
      .hold(hold), .busy_req(busy_req), .req_valid(req_valid_ff),
      .req_ready_ff(req_ready), .bus_busy_ff(bus_busy));

   // =========================================
   // clock, random enable and stalls, timeout
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   always @(negedge clock)
   begin
      clk_en <= ($random(seed) & 7) != 0;
      stall  <= ($random(seed) & 3) == 0;
   end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         fail("run did not finish in time");
         close_out();
      end
   end

   // =========================================
   // output watchers: oldest note against each result
   always @(posedge clock)
   begin
      acc_taken <= acc_valid && acc_ready_ff && clk_en;
      if (reset_n && clk_en && req_valid_ff && req_ready)
      begin
         samples_checked++;
         if (exp_q.size() == 0)
            fail("unexpected bus request");
         else if ({req_kind_ff, req_addr_ff} !== exp_q.pop_front())
            fail("bus request differs from expected");
      end
      if (reset_n && clk_en && l1pf_valid_ff)
      begin
         samples_checked++;
         if (l1_q.size() == 0)
            fail("unexpected first level fill");
         else if (l1pf_addr_ff !== l1_q.pop_front())
            fail("first level fill address wrong");
      end
      if (reset_n && clk_en && pf_cancel_ff)
         cancel_seen++;
   end

   // =========================================
   // tasks
   task automatic fail(input string msg);
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask

   task automatic close_out();
      $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // offers one access at a falling edge and holds it until taken
   task automatic acc(input l2pf_acc_t k, input l2pf_line_t ln,
                      input logic hit);
      int n;
      n = 0;
      while (acc_ready_ff !== 1'b1 && n < 200)
      begin
         @(negedge clock);
         n++;
      end
      acc_valid  = 1'b1;
      acc_kind   = k;
      acc_addr   = {ln, 6'($random(seed))};
      acc_l2_hit = hit;
      @(negedge clock);
      while (acc_taken !== 1'b1 && n < 200)
      begin
         @(negedge clock);
         n++;
      end
      if (n >= 200)
         fail("access never taken");
      samples_checked++;
      if (acc_ready_ff !== hit)
         fail("access ready wrong after take");
      // let an edge pass with valid low before the next offer
      acc_valid = 1'b0;
      @(negedge clock);
   endtask

   task automatic drain();
      int n;
      n = 0;
      while ((exp_q.size() != 0 || l1_q.size() != 0) && n < 300)
      begin
         @(negedge clock);
         n++;
      end
      if (exp_q.size() != 0 || l1_q.size() != 0)
         fail("expected result never appeared");
      repeat (6) @(negedge clock);
   endtask

   // miss: demand, optional stride prefetch, then the pair partner
   task automatic mx(input l2pf_acc_t k, input l2pf_line_t ln,
                     input logic st, input l2pf_line_t sl);
      l2pf_req_t dk;
      dk = (k == L2PF_STORE) ? L2PF_RFO : L2PF_RD;
      exp_q.push_back({dk, ln, 6'h00});
      if (st)
         exp_q.push_back({L2PF_PF, sl, 6'h00});
      exp_q.push_back({L2PF_PF, ln[LINE_W-1:1], ~ln[0], 6'h00});
      acc(k, ln, 1'b0);
      drain();
   endtask

   // =========================================
   // main sequence
   initial
   begin
      seed = 42;
      err_count = 0;
      samples_checked = 0;
      cancel_seen = 0;
      cycles = 0;
      reset_n = 1'b0;
      clk_en = 1'b1;
      stall = 1'b0;
      hold = 1'b0;
      busy_req = 1'b0;
      acc_valid = 1'b0;
      acc_kind = L2PF_LOAD;
      acc_addr = 32'h0000_0000;
      acc_l2_hit = 1'b0;
      acc_taken = 1'b0;
      repeat (12) @(negedge clock);
      reset_n = 1'b1;
      repeat (2) @(negedge clock);
      // seventeen ascending streams; the oldest one is pushed out
      for (int i = 0; i < 17; i++)
      begin
         base = 26'h1000 + 26'(i) * 26'h40;
         mx(L2PF_LOAD, base, 1'b0, base);
         mx(L2PF_LOAD, base + 26'h3, 1'b1, base + 26'h4);
      end
      mx(L2PF_LOAD, 26'h1005, 1'b0, 26'h0);
      mx(L2PF_LOAD, 26'h1045, 1'b1, 26'h1046);
      // software prefetch streams, descending then ascending
      mx(L2PF_SWPF, 26'h3001, 1'b0, 26'h0);
      mx(L2PF_SWPF, 26'h2FFE, 1'b1, 26'h2FFD);
      mx(L2PF_SWPF, 26'h3801, 1'b0, 26'h0);
      mx(L2PF_SWPF, 26'h3805, 1'b1, 26'h3806);
      // store misses at exactly the trigger distance, then load misses one past it
      mx(L2PF_STORE, 26'h4001, 1'b0, 26'h0);
      mx(L2PF_STORE, 26'h4009, 1'b1, 26'h400A);
      mx(L2PF_LOAD, 26'h5000, 1'b0, 26'h0);
      mx(L2PF_LOAD, 26'h5009, 1'b0, 26'h0);
      // heavy bus load while the pair prefetch is still pending
      hold = 1'b1;
      exp_q.push_back({L2PF_RD, 26'h6000, 6'h00});
      n0 = cancel_seen;
      acc(L2PF_LOAD, 26'h6000, 1'b0);
      repeat (6) @(negedge clock);
      busy_req = 1'b1;
      repeat (6) @(negedge clock);
      hold = 1'b0;
      drain();
      if (cancel_seen == n0)
         fail("pending prefetch not cancelled");
      busy_req = 1'b0;
      drain();
      // hits: store hit asks nothing, neighbours feed the first level
      acc(L2PF_LOAD, 26'h7000, 1'b1);
      acc(L2PF_STORE, 26'h7050, 1'b1);
      l1_q.push_back({26'h7052, 6'h00});
      acc(L2PF_SWPF, 26'h7051, 1'b1);
      acc(L2PF_LOAD, 26'h7010, 1'b1);
      l1_q.push_back({26'h700E, 6'h00});
      acc(L2PF_LOAD, 26'h700F, 1'b1);
      drain();
      repeat (20) @(negedge clock);
      close_out();
   end
endmodule

// File: l2pf_top.sv
// module: second-level cache hardware data prefetcher
`timescale 1ns/1ps
// Operation
// - a stream starts only after two misses lie within trigger distance.
// - the tracker holds 16 ascending and 4 descending streams.
// - a miss also requests the partner line of its aligned 128-byte pair.
// - prefetches go to the bus below demand misses in priority.
// - a busy bus queue drops new prefetches and cancels pending ones.
// - a store missing the second-level cache issues a read for ownership.
// - read-for-ownership misses feed the stream detector like loads.
// - software prefetches feed the stream detector as loads.
// - a look-ahead moves predicted lines from second to first level cache.
// - the trigger distance is a fixed 512 or 256 bytes per model.
// - every prefetch moves one whole 64-byte line.
module l2pf_top
(
   // clock, reset, enable
   input  wire logic                         clock,
   input  wire logic                         reset_n,
   input  wire logic                         clk_en,
   // access stream from the load/store path
   input  wire logic                         acc_valid,
   input  wire l2pf_pkg::l2pf_acc_t          acc_kind,
   input  wire logic [l2pf_pkg::ADDR_W-1:0]  acc_addr,
   input  wire logic                         acc_l2_hit,
   output logic                              acc_ready_ff,
   // bus request queue
   output logic                              req_valid_ff,
   output l2pf_pkg::l2pf_req_t               req_kind_ff,
   output logic [l2pf_pkg::ADDR_W-1:0]       req_addr_ff,
   input  wire logic                         req_ready,
   input  wire logic                         bus_busy,
   output logic                              pf_cancel_ff,
   // first-level cache fill from second level
   output logic                              l1pf_valid_ff,
   output logic [l2pf_pkg::ADDR_W-1:0]       l1pf_addr_ff
);
   import l2pf_pkg::*;

   // ==========================================================
   // access decode and stream detection
   l2pf_trk_if a_if ();
   l2pf_trk_if d_if ();

   l2pf_line_t line;
   logic       take;
   logic       miss;
   logic       near_up;
   logic       near_dn;
   logic       new_up;
   logic       new_dn;
   logic       prv_vld_ff;
   l2pf_line_t prv_line_ff;

   assign line = acc_addr[ADDR_W-1:LINE_OFF];
   assign take = clk_en && acc_valid && acc_ready_ff;
   // stores (read for ownership) and software prefetches count as loads
   assign miss = take && !acc_l2_hit;
   assign near_up = prv_vld_ff && l2pf_near(prv_line_ff, line, 1'b1);
   assign near_dn = prv_vld_ff && l2pf_near(prv_line_ff, line, 1'b0);
   assign new_up  = miss && !a_if.hit && !d_if.hit && near_up;
   assign new_dn  = miss && !a_if.hit && !d_if.hit && near_dn && !near_up;

   assign a_if.ce    = clk_en;
   assign a_if.line  = line;
   assign a_if.touch = miss;
   assign a_if.alloc = new_up;
   assign d_if.ce    = clk_en;
   assign d_if.line  = line;
   assign d_if.touch = miss;
   assign d_if.alloc = new_dn;

   l2pf_trk #(.N(ASC_N), .UP(1'b1)) u_asc
   (
      .clock   (clock),
      .reset_n (reset_n),
      .t       (a_if)
   );

   l2pf_trk #(.N(DSC_N), .UP(1'b0)) u_dsc
   (
      .clock   (clock),
      .reset_n (reset_n),
      .t       (d_if)
   );

   // the last miss is the first half of a possible new stream
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prv_vld_ff  <= 1'b0;
         prv_line_ff <= '0;
      end
      else if (miss)
      begin
         prv_vld_ff  <= 1'b1;
         prv_line_ff <= line;
      end
   end

   // ==========================================================
   // demand slot and prefetch slots
   logic       dem_vld_ff;
   l2pf_line_t dem_line_ff;
   l2pf_req_t  dem_kind_ff;
   logic       str_vld_ff;
   l2pf_line_t str_line_ff;
   logic       adj_vld_ff;
   l2pf_line_t adj_line_ff;
   logic       out_free;
   logic       send_dem;
   logic       send_str;
   logic       send_adj;
   logic       str_new;
   logic       nxt_dem_vld;

   assign out_free = clk_en && (!req_valid_ff || req_ready);
   // demand always wins the single bus request slot
   assign send_dem = out_free && dem_vld_ff;
   assign send_str = out_free && !dem_vld_ff && str_vld_ff && !bus_busy;
   assign send_adj = out_free && !dem_vld_ff && !str_vld_ff && adj_vld_ff
                     && !bus_busy;
   assign str_new  = a_if.hit || d_if.hit || new_up || new_dn;
   assign nxt_dem_vld = miss || (dem_vld_ff && !send_dem);

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dem_vld_ff   <= 1'b0;
         dem_line_ff  <= '0;
         dem_kind_ff  <= L2PF_RD;
         acc_ready_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         dem_vld_ff   <= nxt_dem_vld;
         acc_ready_ff <= !nxt_dem_vld;
         if (miss)
         begin
            dem_line_ff <= line;
            dem_kind_ff <= (acc_kind == L2PF_STORE) ? L2PF_RFO : L2PF_RD;
         end
      end
   end

   // a busy queue cancels what waits and refuses what is new
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         str_vld_ff   <= 1'b0;
         str_line_ff  <= '0;
         adj_vld_ff   <= 1'b0;
         adj_line_ff  <= '0;
         pf_cancel_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         pf_cancel_ff <= bus_busy && (str_vld_ff || adj_vld_ff);
         if (bus_busy)
         begin
            str_vld_ff <= 1'b0;
            adj_vld_ff <= 1'b0;
         end
         else
         begin
            if (miss && str_new)
            begin
               str_vld_ff  <= 1'b1;
               str_line_ff <= (a_if.hit || new_up) ? line + LINE_STEP
                                                   : line - LINE_STEP;
            end
            else if (send_str)
               str_vld_ff <= 1'b0;
            if (miss)
            begin
               adj_vld_ff  <= 1'b1;
               adj_line_ff <= line ^ PAIR_BIT;
            end
            else if (send_adj)
               adj_vld_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // bus request register
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         req_valid_ff <= 1'b0;
         req_kind_ff  <= L2PF_RD;
         req_addr_ff  <= '0;
      end
      else if (out_free)
      begin
         req_valid_ff <= send_dem || send_str || send_adj;
         if (send_dem)
         begin
            req_kind_ff <= dem_kind_ff;
            req_addr_ff <= l2pf_addr(dem_line_ff);
         end
         else if (send_str || send_adj)
         begin
            req_kind_ff <= L2PF_PF;
            req_addr_ff <= l2pf_addr(send_str ? str_line_ff
                                              : adj_line_ff);
         end
      end
   end

   // ==========================================================
   // first-level look-ahead on sequential hits
   l2pf_line_t l1_last_ff;
   logic       l1_seq_up;
   logic       l1_seq_dn;

   assign l1_seq_up = take && acc_l2_hit && line == l1_last_ff + LINE_STEP;
   assign l1_seq_dn = take && acc_l2_hit && line + LINE_STEP == l1_last_ff;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         l1_last_ff    <= '0;
         l1pf_valid_ff <= 1'b0;
         l1pf_addr_ff  <= '0;
      end
      else if (clk_en)
      begin
         l1pf_valid_ff <= l1_seq_up || l1_seq_dn;
         if (take)
            l1_last_ff <= line;
         if (l1_seq_up || l1_seq_dn)
            l1pf_addr_ff <= l2pf_addr(l1_seq_up ? line + LINE_STEP
                                                : line - LINE_STEP);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence s_store_miss;
      miss && acc_kind == L2PF_STORE;
   endsequence

   sequence s_swpf_up;
      miss && acc_kind == L2PF_SWPF && new_up && !bus_busy;
   endsequence

   a_first_miss: assert property (
      miss && !prv_vld_ff |-> !a_if.alloc && !d_if.alloc ##1 !str_vld_ff)
      else $error("stream started from a single miss");

   a_demand_first: assert property (
      send_dem |=> req_valid_ff && req_kind_ff != L2PF_PF)
      else $error("prefetch issued ahead of a pending demand");

   a_adj_pair: assert property (
      miss && !bus_busy |=> adj_vld_ff
      && adj_line_ff == ($past(line) ^ PAIR_BIT))
      else $error("partner line not queued after a miss");

   a_busy_drop: assert property (
      clk_en && bus_busy |=> !adj_vld_ff && !str_vld_ff)
      else $error("prefetch kept while the bus queue was busy");

   a_rfo_kind: assert property (
      s_store_miss |=> dem_vld_ff && dem_kind_ff == L2PF_RFO
      ##0 !acc_ready_ff)
      else $error("store miss did not become a read for ownership");

   a_rfo_stream: assert property (
      s_store_miss ##0 near_up && !a_if.hit && !d_if.hit |-> a_if.alloc ##1
      $past(bus_busy) || str_vld_ff && str_line_ff == $past(line) + LINE_STEP)
      else $error("read for ownership ignored by the detector");

   a_swpf_stream: assert property (
      s_swpf_up |=> str_vld_ff && str_line_ff == $past(line) + LINE_STEP)
      else $error("software prefetch did not start a stream");

   a_l1_ahead: assert property (
      clk_en && l1_seq_up |=> l1pf_valid_ff
      && l1pf_addr_ff == l2pf_addr($past(line) + LINE_STEP))
      else $error("look-ahead missed the next sequential line");

   a_whole_line: assert property (
      req_valid_ff |-> req_addr_ff[LINE_OFF-1:0] == '0)
      else $error("bus request not line aligned");

   a_req_hold: assert property (
      req_valid_ff && !req_ready |=> req_valid_ff && $stable(req_addr_ff))
      else $error("bus request changed before it was taken");
endmodule

// File: l2pf_trk.sv
// module: stream tracker table for one direction with true LRU
`timescale 1ns/1ps
module l2pf_trk
#(
   parameter int N  = 16,
   parameter bit UP = 1'b1
)
(
   // clock and reset
   input wire logic             clock,
   input wire logic             reset_n,
   // lookup and update
   l2pf_trk_if.table_side       t
);
   import l2pf_pkg::*;

   localparam int AW = $clog2(N);
   localparam logic [AW-1:0] AGE_OLD = AW'(N - 1);

   logic [N-1:0]  vld_ff;
   l2pf_line_t    last_ff [N];
   logic [AW-1:0] age_ff  [N];
   logic [N-1:0]  hit_v;
   logic [AW-1:0] sel;
   logic [AW-1:0] sel_age;
   logic          found;
   logic          wr;

   // sel: hitting entry, else a free one, else the least recently used
   always_comb
   begin
      hit_v = '0;
      sel   = '0;
      found = 1'b0;
      for (int i = 0; i < N; i++)
      begin
         hit_v[i] = vld_ff[i] && l2pf_near(last_ff[i], t.line, UP);
      end
      for (int i = 0; i < N; i++)
      begin
         if (!found && hit_v[i])
         begin
            sel   = AW'(i);
            found = 1'b1;
         end
      end
      for (int i = 0; i < N; i++)
      begin
         if (!found && !vld_ff[i])
         begin
            sel   = AW'(i);
            found = 1'b1;
         end
      end
      for (int i = 0; i < N; i++)
      begin
         if (!found && age_ff[i] == AGE_OLD)
         begin
            sel   = AW'(i);
            found = 1'b1;
         end
      end
      sel_age = age_ff[sel];
   end

   assign t.hit = |hit_v;
   assign wr    = t.ce && ((t.touch && t.hit) || (t.alloc && !t.hit));

   // ages stay a permutation, so exactly one entry is the oldest
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         vld_ff <= '0;
         for (int i = 0; i < N; i++)
         begin
            last_ff[i] <= '0;
            age_ff[i]  <= AW'(i);
         end
      end
      else if (wr)
      begin
         vld_ff[sel]  <= 1'b1;
         last_ff[sel] <= t.line;
         for (int i = 0; i < N; i++)
         begin
            if (AW'(i) == sel)
               age_ff[i] <= '0;
            else if (age_ff[i] < sel_age)
               age_ff[i] <= age_ff[i] + 1'b1;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_lru_replace: assert property (
      t.ce && t.alloc && !t.hit && (&vld_ff) && age_ff[0] == AGE_OLD
      |=> (&vld_ff) && last_ff[0] == $past(t.line) && age_ff[0] == '0)
      else $error("full table did not replace its oldest entry");
endmodule

// File: l2pf_trk_if.sv
// interface: lookup and update port of one stream tracker table
`timescale 1ns/1ps
interface l2pf_trk_if;
   import l2pf_pkg::*;
   logic       ce;
   l2pf_line_t line;
   logic       touch;
   logic       alloc;
   logic       hit;

   modport table_side (input ce, line, touch, alloc, output hit);
   modport user_side  (output ce, line, touch, alloc, input hit);
endinterface
